// *** hw/sfc_channel.sv ***
/*
 * one flagged synchronous fifo channel with an axi4-lite register slave.
 * pin clocks and controls are sampled on aclk through sfc_sync; a pin
 * clock rising edge is a write or read event. assumes pin clocks are far
 * slower than aclk and that the data bus wire is resolved outside.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sfc_regs.svh"

module sfc_channel (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic write_clock,
    input wire logic read_clock,
    input wire logic write_enable_primary_n,
    input wire logic write_enable_second_or_offset_load,
    input wire logic read_enable_first_n,
    input wire logic read_enable_second_n,
    input wire logic output_enable_n,
    input wire logic [`SFC_DATA_W-1:0] write_data_in,
    output logic [`SFC_DATA_W-1:0] read_data_out,
    output logic read_data_out_oe_n,
    output logic empty_flag_n,
    output logic almost_empty_flag_n,
    output logic full_flag_n,
    output logic almost_full_flag_n,
    output logic interrupt,
    input wire logic [`SFC_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`SFC_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    sfc_pkg::sfc_state_t s;
    sfc_pkg::sfc_state_t n;
    logic [`SFC_SYNC_W-1:0] pins;
    logic [`SFC_SYNC_W-1:0] pin;
    logic [`SFC_DATA_W-1:0] din;
    logic wedge;
    logic redge;
    logic wen1_n;
    logic wen2;
    logic ren_n;
    logic wr_req;
    logic ld_req;
    logic rd_req;
    logic rb_req;
    logic do_write;
    logic do_read;
    logic [`SFC_CNT_W-1:0] free;
    logic [`SFC_EV_W-1:0] ev;
    logic [`SFC_EV_W-1:0] clr;
    logic [`SFC_ADDR_W-1:0] raddr;

    ////////////////////////////////////////////////////////////////////////
    // pin sampling, all pins share one delay so data lines up with clocks
    assign pins = {write_data_in, output_enable_n, read_enable_second_n,
                   read_enable_first_n, write_enable_second_or_offset_load,
                   write_enable_primary_n, read_clock, write_clock};

    sfc_sync u_sync (
        .aclk(aclk),
        .pins(pins),
        .stable(pin)
    );

    // decoded pin events and levels
    assign din = pin[`SFC_PIN_DATA +: `SFC_DATA_W];
    assign wedge = pin[`SFC_PIN_WCLK] & ~s.wclk_q;
    assign redge = pin[`SFC_PIN_RCLK] & ~s.rclk_q;
    assign wen1_n = pin[`SFC_PIN_WEN1];
    assign wen2 = pin[`SFC_PIN_WEN2];
    assign ren_n = pin[`SFC_PIN_REN1] | pin[`SFC_PIN_REN2];

    ////////////////////////////////////////////////////////////////////////
    // write side qualification
    always_comb begin
        wr_req = 1'b0;
        ld_req = 1'b0;
        if (wedge && !wen1_n) begin
            if (s.prog_mode) begin
                // shared pin is load only; low selects offset access
                ld_req = ~wen2;
                wr_req = wen2;
            end else begin
                wr_req = wen2;
            end
        end
    end

    // full channel refuses the write, pointer and contents untouched
    assign do_write = wr_req & s.ff_n;

    ////////////////////////////////////////////////////////////////////////
    // read side qualification
    always_comb begin
        rd_req = 1'b0;
        rb_req = 1'b0;
        if (redge && !ren_n) begin
            if (s.prog_mode && !wen2) begin
                rb_req = 1'b1;
            end else begin
                rd_req = 1'b1;
            end
        end
    end

    // empty channel refuses the read, output word held
    assign do_read = rd_req & s.ef_n;

    assign raddr = {s_axi_araddr[`SFC_ADDR_W-1:2], 2'h0};

    ////////////////////////////////////////////////////////////////////////
    // next state of the whole channel
    always_comb begin
        n = s;
        free = 9'h000;
        clr = '0;
        n.wclk_q = pin[`SFC_PIN_WCLK];
        n.rclk_q = pin[`SFC_PIN_RCLK];
        n.q_oe_n = pin[`SFC_PIN_OE];

        // storage and write pointer
        if (do_write) begin
            n.mem[s.wr_ptr] = din;
            n.wr_ptr = s.wr_ptr + 8'h01;
        end

        // output word and read pointer; output enable plays no part
        if (do_read) begin
            n.q = s.mem[s.rd_ptr];
            n.rd_ptr = s.rd_ptr + 8'h01;
        end

        // occupancy shared by both flag groups, one clock so no crossing
        n.count = s.count + {8'h00, do_write} - {8'h00, do_read};

        // offset readback over the data pins
        if (rb_req) begin
            if (s.rb_sel == sfc_pkg::SFC_SEL_EMPTY) begin
                n.q = {1'b0, s.empty_ofs};
                n.rb_sel = sfc_pkg::SFC_SEL_FULL;
            end else begin
                n.q = {1'b0, s.full_ofs};
                n.rb_sel = sfc_pkg::SFC_SEL_EMPTY;
            end
        end

        // register bus write side: address and data in either order
        if (s_axi_awvalid && s.awready) begin
            n.aw_got = 1'b1;
            n.awready = 1'b0;
            n.waddr = {s_axi_awaddr[`SFC_ADDR_W-1:2], 2'h0};
        end
        if (s_axi_wvalid && s.wready) begin
            n.w_got = 1'b1;
            n.wready = 1'b0;
            n.wdata = s_axi_wdata;
            n.wstrb0 = s_axi_wstrb[0];
        end
        case (s.wst)
            sfc_pkg::SFC_WR_COLLECT: begin
                if (s.aw_got && s.w_got) begin
                    n.bresp = `SFC_RESP_OKAY;
                    n.bvalid = 1'b1;
                    n.wst = sfc_pkg::SFC_WR_RESP;
                    case (s.waddr)
                        `SFC_STATUS_ADDR: begin
                            if (s.wstrb0) begin
                                clr = s.wdata[`SFC_EV_W-1:0];
                            end
                        end
                        `SFC_MASK_ADDR: begin
                            if (s.wstrb0) begin
                                n.mask = s.wdata[`SFC_EV_W-1:0];
                            end
                        end
                        `SFC_EMPTY_OFS_ADDR: begin
                            if (s.wstrb0) begin
                                n.empty_ofs = s.wdata[`SFC_OFS_W-1:0];
                            end
                        end
                        `SFC_FULL_OFS_ADDR: begin
                            if (s.wstrb0) begin
                                n.full_ofs = s.wdata[`SFC_OFS_W-1:0];
                            end
                        end
                        `SFC_LEVEL_ADDR: begin
                            n.bresp = `SFC_RESP_OKAY;
                        end
                        default: begin
                            n.bresp = `SFC_RESP_SLVERR;
                        end
                    endcase
                end
            end
            sfc_pkg::SFC_WR_RESP: begin
                if (s_axi_bready) begin
                    n.bvalid = 1'b0;
                    n.aw_got = 1'b0;
                    n.w_got = 1'b0;
                    n.awready = 1'b1;
                    n.wready = 1'b1;
                    n.wst = sfc_pkg::SFC_WR_COLLECT;
                end
            end
            default: begin
                n.wst = sfc_pkg::SFC_WR_COLLECT;
            end
        endcase

        // pin offset load follows a bus write in the same cycle
        if (ld_req) begin
            if (s.ld_sel == sfc_pkg::SFC_SEL_EMPTY) begin
                n.empty_ofs = din[`SFC_OFS_W-1:0];
                n.ld_sel = sfc_pkg::SFC_SEL_FULL;
            end else begin
                n.full_ofs = din[`SFC_OFS_W-1:0];
                n.ld_sel = sfc_pkg::SFC_SEL_EMPTY;
            end
        end

        // register bus read side, one word answered the cycle after
        if (s_axi_arvalid && s.arready) begin
            n.arready = 1'b0;
            n.rvalid = 1'b1;
            n.rresp = `SFC_RESP_OKAY;
            n.rdata = 32'h0000_0000;
            case (raddr)
                `SFC_STATUS_ADDR: begin
                    n.rdata[`SFC_EV_W-1:0] = s.status;
                end
                `SFC_MASK_ADDR: begin
                    n.rdata[`SFC_EV_W-1:0] = s.mask;
                end
                `SFC_EMPTY_OFS_ADDR: begin
                    n.rdata[`SFC_OFS_W-1:0] = s.empty_ofs;
                end
                `SFC_FULL_OFS_ADDR: begin
                    n.rdata[`SFC_OFS_W-1:0] = s.full_ofs;
                end
                `SFC_LEVEL_ADDR: begin
                    n.rdata[`SFC_CNT_W-1:0] = s.count;
                    n.rdata[`SFC_LEVEL_MODE_BIT] = s.prog_mode;
                end
                default: begin
                    n.rresp = `SFC_RESP_SLVERR;
                end
            endcase
        end else if (s.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
            n.arready = 1'b1;
        end

        // flags follow the new occupancy and offsets
        free = `SFC_FULL_CNT - n.count;
        n.ef_n = (n.count != 9'h000);
        n.aef_n = ~(n.count <= {1'b0, n.empty_ofs});
        n.ff_n = (n.count != `SFC_FULL_CNT);
        n.aff_n = ~(free <= {1'b0, n.full_ofs});

        // events raised to the status register, once the new flags are known
        ev = '0;
        ev[`SFC_EV_WR_REFUSED] = wr_req & ~s.ff_n;
        ev[`SFC_EV_RD_REFUSED] = rd_req & ~s.ef_n;
        ev[`SFC_EV_ALMOST_FULL] = s.aff_n & ~n.aff_n;
        ev[`SFC_EV_ALMOST_EMPTY] = s.aef_n & ~n.aef_n;

        // sticky status, a new event wins over a clear
        n.status = (s.status & ~clr) | ev;
        n.irq = |(n.status & n.mask);

        // reset: pointers home, flags to reset levels, strap caught
        if (!aresetn) begin
            n.wr_ptr = '0;
            n.rd_ptr = '0;
            n.count = '0;
            n.ef_n = 1'b0;
            n.aef_n = 1'b0;
            n.ff_n = 1'b1;
            n.aff_n = 1'b1;
            // shared pin high selects dual enables, low selects load
            n.prog_mode = ~pin[`SFC_PIN_WEN2];
            n.ld_sel = sfc_pkg::SFC_SEL_EMPTY;
            n.rb_sel = sfc_pkg::SFC_SEL_EMPTY;
            n.empty_ofs = `SFC_EMPTY_OFS_RST;
            n.full_ofs = `SFC_FULL_OFS_RST;
            n.wclk_q = 1'b1;
            n.rclk_q = 1'b1;
            n.q = '0;
            n.q_oe_n = 1'b1;
            n.status = '0;
            n.mask = '0;
            n.irq = 1'b0;
            n.wst = sfc_pkg::SFC_WR_COLLECT;
            n.aw_got = 1'b0;
            n.w_got = 1'b0;
            n.waddr = '0;
            n.wdata = '0;
            n.wstrb0 = 1'b0;
            n.awready = 1'b1;
            n.wready = 1'b1;
            n.bvalid = 1'b0;
            n.bresp = `SFC_RESP_OKAY;
            n.arready = 1'b1;
            n.rvalid = 1'b0;
            n.rdata = '0;
            n.rresp = `SFC_RESP_OKAY;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // the single state register
    always_ff @(posedge aclk) begin
        s <= n;
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs straight from the state register
    assign read_data_out = s.q;
    assign read_data_out_oe_n = s.q_oe_n;
    assign empty_flag_n = s.ef_n;
    assign almost_empty_flag_n = s.aef_n;
    assign full_flag_n = s.ff_n;
    assign almost_full_flag_n = s.aff_n;
    assign interrupt = s.irq;
    assign s_axi_awready = s.awready;
    assign s_axi_wready = s.wready;
    assign s_axi_bresp = s.bresp;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_arready = s.arready;
    assign s_axi_rdata = s.rdata;
    assign s_axi_rresp = s.rresp;
    assign s_axi_rvalid = s.rvalid;

endmodule

`default_nettype wire

// *** hw/sfc_sync.sv ***
/*
 * three-stage pin synchroniser with agreement filter for all pin inputs.
 * assumes pins are asynchronous to aclk and change slower than aclk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sfc_regs.svh"

module sfc_sync (
    input wire logic aclk,
    input wire logic [`SFC_SYNC_W-1:0] pins,
    output logic [`SFC_SYNC_W-1:0] stable
);

    sfc_pkg::sfc_sync_t r;
    sfc_pkg::sfc_sync_t next_r;
    logic [`SFC_SYNC_W-1:0] next_stable;

    ////////////////////////////////////////////////////////////////////////
    // a change is taken once the second and third stages agree
    genvar i;
    generate
        for (i = 0; i < `SFC_SYNC_W; i = i + 1) begin : g_bit
            assign next_stable[i] = (r.s2[i] == r.s3[i]) ? r.s3[i] : r.stable[i];
        end
    endgenerate

    // shift chain; first stage feeds only the second
    always_comb begin
        next_r = r;
        next_r.s1 = pins;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
        next_r.stable = next_stable;
    end

    always_ff @(posedge aclk) begin
        r <= next_r;
    end

    assign stable = r.stable;

endmodule

`default_nettype wire

// *** include/sfc_pkg.sv ***
/*
 * types of the flagged synchronous fifo channel.
 * assumes sfc_regs.svh on the include path.
 */
`include "sfc_regs.svh"

package sfc_pkg;

    // which offset the next load or readback touches
    typedef enum logic {
        SFC_SEL_EMPTY,
        SFC_SEL_FULL
    } sfc_sel_t;

    // register bus write progress
    typedef enum logic {
        SFC_WR_COLLECT,
        SFC_WR_RESP
    } sfc_wst_t;

    typedef struct packed {
        logic [`SFC_SYNC_W-1:0] s1;
        logic [`SFC_SYNC_W-1:0] s2;
        logic [`SFC_SYNC_W-1:0] s3;
        logic [`SFC_SYNC_W-1:0] stable;
    } sfc_sync_t;

    typedef struct packed {
        logic [`SFC_DEPTH-1:0][`SFC_DATA_W-1:0] mem;
        logic [`SFC_PTR_W-1:0] wr_ptr;
        logic [`SFC_PTR_W-1:0] rd_ptr;
        logic [`SFC_CNT_W-1:0] count;
        logic prog_mode;
        sfc_sel_t ld_sel;
        sfc_sel_t rb_sel;
        logic [`SFC_OFS_W-1:0] empty_ofs;
        logic [`SFC_OFS_W-1:0] full_ofs;
        logic wclk_q;
        logic rclk_q;
        logic [`SFC_DATA_W-1:0] q;
        logic q_oe_n;
        logic ef_n;
        logic aef_n;
        logic ff_n;
        logic aff_n;
        logic [`SFC_EV_W-1:0] status;
        logic [`SFC_EV_W-1:0] mask;
        logic irq;
        sfc_wst_t wst;
        logic aw_got;
        logic w_got;
        logic [`SFC_ADDR_W-1:0] waddr;
        logic [31:0] wdata;
        logic wstrb0;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } sfc_state_t;

endpackage

// *** include/sfc_regs.svh ***
/*
 * constants of the flagged synchronous fifo channel: sizes, reset values,
 * register offsets, interrupt event bits and pin vector positions.
 * assumes inclusion by bare name from the package and the channel module.
 */
`ifndef SFC_REGS_SVH
`define SFC_REGS_SVH

`define SFC_DATA_W 9
`define SFC_DEPTH 256
`define SFC_PTR_W 8
`define SFC_CNT_W 9
`define SFC_OFS_W 8
`define SFC_FULL_CNT 9'h100
`define SFC_EMPTY_OFS_RST 8'h07
`define SFC_FULL_OFS_RST 8'h07

`define SFC_ADDR_W 8
`define SFC_STATUS_ADDR 8'h00
`define SFC_MASK_ADDR 8'h04
`define SFC_EMPTY_OFS_ADDR 8'h08
`define SFC_FULL_OFS_ADDR 8'h0c
`define SFC_LEVEL_ADDR 8'h10
`define SFC_LEVEL_MODE_BIT 9
`define SFC_RESP_OKAY 2'h0
`define SFC_RESP_SLVERR 2'h2

`define SFC_EV_W 4
`define SFC_EV_WR_REFUSED 0
`define SFC_EV_RD_REFUSED 1
`define SFC_EV_ALMOST_FULL 2
`define SFC_EV_ALMOST_EMPTY 3

`define SFC_SYNC_W 16
`define SFC_PIN_WCLK 0
`define SFC_PIN_RCLK 1
`define SFC_PIN_WEN1 2
`define SFC_PIN_WEN2 3
`define SFC_PIN_REN1 4
`define SFC_PIN_REN2 5
`define SFC_PIN_OE 6
`define SFC_PIN_DATA 7

`endif

// *** tb/sfc_host.sv ***
/* far-side host model: write-side and read-side pin logic of one channel.
   assumes aclk from the bench; pulses are slow against aclk. */
`timescale 1ns/1ps
`default_nettype none
`include "sfc_regs.svh"
module sfc_host (
    input wire logic aclk,
    output logic write_clock,
    output logic read_clock,
    output logic write_enable_primary_n,
    output logic write_enable_second_or_offset_load,
    output logic read_enable_first_n,
    output logic read_enable_second_n,
    output logic [`SFC_DATA_W-1:0] write_data_in
);
    ////////////////////////////////////////
    // idle pins; pin clocks stand still low between pulses
    initial begin
        write_clock = 1'b0;
        read_clock = 1'b0;
        write_enable_primary_n = 1'b1;
        write_enable_second_or_offset_load = 1'b1;
        read_enable_first_n = 1'b1;
        read_enable_second_n = 1'b1;
        write_data_in = 9'h000;
    end
    // shared pin level, sampled as strap during reset
    task automatic set_load(input logic v);
        write_enable_second_or_offset_load <= v;
    endtask
    // one write pulse, data and enables held four cycles around the edge
    task automatic wr(input logic [`SFC_DATA_W-1:0] d, input logic en1_n, input logic en2);
        @(posedge aclk);
        write_data_in <= d;
        write_enable_primary_n <= en1_n;
        write_enable_second_or_offset_load <= en2;
        repeat (4) @(posedge aclk);
        write_clock <= 1'b1;
        repeat (4) @(posedge aclk);
        write_clock <= 1'b0;
        repeat (4) @(posedge aclk);
        write_data_in <= ~d; // released bus shows a changed value
        write_enable_primary_n <= 1'b1;
        write_enable_second_or_offset_load <= 1'b1;
    endtask
    // one read pulse; load low asks for offset readback
    task automatic rd(input logic en1_n, input logic en2_n, input logic ld_n);
        @(posedge aclk);
        read_enable_first_n <= en1_n;
        read_enable_second_n <= en2_n;
        write_enable_second_or_offset_load <= ld_n;
        repeat (4) @(posedge aclk);
        read_clock <= 1'b1;
        repeat (4) @(posedge aclk);
        read_clock <= 1'b0;
        repeat (4) @(posedge aclk);
        read_enable_first_n <= 1'b1;
        read_enable_second_n <= 1'b1;
        write_enable_second_or_offset_load <= 1'b1;
    endtask
endmodule
`default_nettype wire

// *** tb/sfc_props.sv ***
/* port checker for the flagged fifo channel.
   assumes a bind onto sfc_channel and pin clocks far slower than aclk. */
`timescale 1ns/1ps
`default_nettype none
`include "sfc_regs.svh"
module sfc_props (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic write_clock,
    input wire logic read_clock,
    input wire logic write_enable_second_or_offset_load,
    input wire logic output_enable_n,
    input wire logic [`SFC_DATA_W-1:0] read_data_out,
    input wire logic read_data_out_oe_n,
    input wire logic empty_flag_n,
    input wire logic almost_empty_flag_n,
    input wire logic full_flag_n,
    input wire logic almost_full_flag_n,
    input wire logic interrupt,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid
);
    ////////////////////////////////////////
    // one domain; reset disables every check
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // write address and data taken together, then the response
    sequence both_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence resp_after;
        !s_axi_awready ##1 s_axi_bvalid;
    endsequence
    chk_reset_levels: assert property ($rose(aresetn) |-> !empty_flag_n &&
        !almost_empty_flag_n && full_flag_n && almost_full_flag_n && !interrupt)
        else $error("flags not at reset levels");
    chk_full_levels: assert property (
        !full_flag_n |-> empty_flag_n && !almost_full_flag_n) else $error("full flag levels");
    chk_empty_levels: assert property (
        !empty_flag_n |-> full_flag_n && !almost_empty_flag_n) else $error("empty flag levels");
    chk_drive_follow: assert property (
        ($past(aresetn) && $stable(output_enable_n))[*8] |->
        read_data_out_oe_n == output_enable_n)
        else $error("drive enable does not follow");
    chk_word_hold: assert property (write_enable_second_or_offset_load[*8] ##1
        $changed(read_data_out) |-> $past(empty_flag_n)) else $error("word changed while empty");
    chk_full_release: assert property (
        $rose(full_flag_n) |-> $past(read_clock, 4) || $past(read_clock, 5))
        else $error("full released without read");
    chk_empty_release: assert property (
        $rose(empty_flag_n) |-> $past(write_clock, 4) || $past(write_clock, 5))
        else $error("empty released without write");
    chk_write_resp: assert property (both_taken |=> resp_after)
        else $error("write response out of step");
endmodule
`default_nettype wire

// *** tb/tb.sv ***
/* self-checking bench for the fifo channel with pin host and axi4-lite master.
   assumes design, sfc_host and sfc_props are compiled before it. */
`timescale 1ns/1ps
`default_nettype none
`include "sfc_regs.svh"
module tb;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic output_enable_n = 1'b0;
    logic write_clock, read_clock, write_enable_primary_n, write_enable_second_or_offset_load;
    logic read_enable_first_n, read_enable_second_n, read_data_out_oe_n, interrupt;
    logic empty_flag_n, almost_empty_flag_n, full_flag_n, almost_full_flag_n;
    logic [`SFC_DATA_W-1:0] write_data_in, read_data_out;
    logic [`SFC_ADDR_W-1:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_word;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    int mismatches = 0;
    int checked = 0;
    sfc_channel dut (.*);
    sfc_host h (.*);
    ////////////////////////////////////////
    // 50 ns clock and hang watchdog
    initial begin
        forever #25 aclk = ~aclk;
    end
    initial begin
        #(20000 * 50);
        mismatches++;
        test_done();
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        if (mismatches == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    function automatic logic [3:0] flags();
        return {empty_flag_n, almost_empty_flag_n, full_flag_n, almost_full_flag_n};
    endfunction
    // one register access; each channel released when taken, watchdog ends a hang
    task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= wr;
        s_axi_wvalid <= wr;
        s_axi_arvalid <= !wr;
        s_axi_bready <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!(s_axi_bvalid || s_axi_rvalid));
        rd_word = s_axi_rdata;
        resp = wr ? s_axi_bresp : s_axi_rresp;
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        axi(1'b0, a, 32'h0);
        check(rd_word, exp);
    endtask
    // reset with the shared pin as strap, then pin clocks low a while
    task automatic do_reset(input logic strap);
        @(posedge aclk);
        aresetn <= 1'b0;
        h.set_load(strap);
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (6) @(posedge aclk);
        h.set_load(1'b1);
        repeat (6) @(posedge aclk);
    endtask
    task automatic t_reset;
        check(flags(), 4'h3);
        rdchk(`SFC_EMPTY_OFS_ADDR, 32'h7);
        rdchk(`SFC_FULL_OFS_ADDR, 32'h7);
        rdchk(`SFC_LEVEL_ADDR, 32'h0);
        axi(1'b0, 8'h20, 32'h0);
        check(resp, 2'h2);
        axi(1'b1, 8'h24, 32'h1);
        check(resp, 2'h2);
    endtask
    task automatic t_irq;
        h.rd(1'b0, 1'b0, 1'b1);
        check(read_data_out, 9'h000);
        axi(1'b0, `SFC_STATUS_ADDR, 32'h0);
        check(rd_word[1:0], 2'h2);
        check(interrupt, 1'b0);
        axi(1'b1, `SFC_MASK_ADDR, 32'h2);
        repeat (3) @(posedge aclk);
        check(interrupt, 1'b1);
        axi(1'b1, `SFC_STATUS_ADDR, 32'hf);
        repeat (3) @(posedge aclk);
        check(interrupt, 1'b0);
        axi(1'b1, `SFC_MASK_ADDR, 32'h0);
    endtask
    task automatic t_fill;
        h.wr(9'h155, 1'b0, 1'b0);
        h.wr(9'h0aa, 1'b1, 1'b1);
        check(flags(), 4'h3);
        for (int i = 1; i <= 256; i++) begin
            h.wr(9'(i) ^ 9'h1a5, 1'b0, 1'b1);
            check(flags(), {1'b1, i > 7, i < 256, i < 249});
        end
        h.wr(9'h0f0, 1'b0, 1'b1);
        rdchk(`SFC_LEVEL_ADDR, 32'h100);
        axi(1'b0, `SFC_STATUS_ADDR, 32'h0);
        check(rd_word[0], 1'b1);
        axi(1'b1, `SFC_STATUS_ADDR, 32'hf);
    endtask
    task automatic t_drain;
        h.rd(1'b0, 1'b1, 1'b1);
        check(full_flag_n, 1'b0);
        for (int i = 1; i <= 256; i++) begin
            output_enable_n <= i[0];
            h.rd(1'b0, 1'b0, 1'b1);
            check(read_data_out, 9'(i) ^ 9'h1a5);
            check(read_data_out_oe_n, i[0]);
            check(flags(), {i < 256, i < 249, 1'b1, i > 7});
        end
        h.rd(1'b0, 1'b0, 1'b1);
        check(read_data_out, 9'h0a5);
    endtask
    task automatic t_prog;
        h.wr(9'h011, 1'b0, 1'b1);
        do_reset(1'b0);
        check(flags(), 4'h3);
        rdchk(`SFC_LEVEL_ADDR, 32'h200);
        h.wr(9'h003, 1'b0, 1'b0);
        h.wr(9'h005, 1'b0, 1'b0);
        rdchk(`SFC_EMPTY_OFS_ADDR, 32'h3);
        rdchk(`SFC_FULL_OFS_ADDR, 32'h5);
        h.rd(1'b0, 1'b0, 1'b0);
        check(read_data_out, 9'h003);
        h.rd(1'b0, 1'b0, 1'b0);
        check(read_data_out, 9'h005);
        for (int i = 1; i <= 4; i++) begin
            h.wr(9'h100, 1'b0, 1'b1);
            check(almost_empty_flag_n, i > 3);
        end
    endtask
    // main sequence
    initial begin
        do_reset(1'b1);
        t_reset();
        t_irq();
        t_fill();
        t_drain();
        t_prog();
        test_done();
    end
endmodule
bind sfc_channel sfc_props chk (.*);
`default_nettype wire
